//--- wdog_pkg.sv
package wdog_pkg;

	// ************************************************************
	// register map and field layout
	// ************************************************************
	localparam logic [7:0] SERVICE_KEY_ADDR   = 8'hA6;  // write-only service register
	localparam logic [7:0] PRESCALE_SEL_ADDR  = 8'hA7;  // prescale select register
	localparam logic [7:0] KEY_FIRST          = 8'h1E;
	localparam logic [7:0] KEY_SECOND         = 8'hE1;
	localparam int         PRESCALE_SEL_LSB   = 0;
	localparam int         PRESCALE_SEL_W     = 3;
	localparam logic [2:0] PRESCALE_SEL_RESET = 3'h0;
	localparam int         DOUBLE_SPEED_POS   = 0;      // bit 0 of the clock control byte

	// ************************************************************
	// timing constants
	// ************************************************************
	localparam int         WDOG_COUNT_W       = 14;
	localparam logic [13:0] WDOG_COUNT_MAX    = 14'h3FFF; // 16383
	localparam int         PRESCALE_STAGES    = 7;        // extra 2^7 stage
	localparam int         MC_PERIODS_STD     = 12;
	localparam int         MC_PERIODS_X2      = 6;
	localparam int         RESET_PULSE_PERIODS = 96;

	// ************************************************************
	// carriers and states
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} sfr_wr_s;

	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b001,
		KEY_HALF  = 3'b010,
		KEY_DONE  = 3'b100
	} key_state_e;

endpackage : wdog_pkg

//--- wdog_tick_gen.sv
`timescale 1ns/1ps
// machine cycle strobe: one pulse every 12 or 6 oscillator periods
module wdog_tick_gen (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	// control
	input  wire logic i_double_speed,
	// strobe
	output logic      o_tick
);
	import wdog_pkg::*;

	logic [3:0] div_r;
	logic [3:0] div_nxt;
	logic       tick_r;
	logic       tick_nxt;
	logic [3:0] last;

	// divider wraps at the period for the current speed
	always_comb begin
		last     = i_double_speed ? 4'(MC_PERIODS_X2 - 1) : 4'(MC_PERIODS_STD - 1); // R11
		tick_nxt = (div_r >= last);
		div_nxt  = tick_nxt ? 4'h0 : div_r + 4'h1;
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_r  <= 4'h0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

endmodule : wdog_tick_gen

//--- hardware_watchdog_timer.sv
`timescale 1ns/1ps
// Contract
// R1: watchdog disabled after any reset
// R2: writing 1E then E1 arms watchdog
// R3: counter advances once per machine cycle
// R4: only reset disables an armed watchdog; here an overflow also clears the enable
// R5: 14-bit counter overflows at 16383, resets
// R6: key sequence restarts count from zero
// R7: software services within 16383 machine cycles
// R8: service register write-only, counter hidden
// R9: overflow drives 96-period high reset pulse
// R10: extra 2^7 prescaler stage before counter
// R11: machine cycle 12 periods, 6 doubled
// R12: broken key sequence is abandoned
// R13: prescaler depth chosen by select field
module hardware_watchdog_timer #(
	parameter int CNT_W     = wdog_pkg::WDOG_COUNT_W,        // watchdog count width
	parameter int PRE_W     = wdog_pkg::PRESCALE_STAGES,     // extra prescale stages
	parameter int PULSE_LEN = wdog_pkg::RESET_PULSE_PERIODS  // reset pulse length in clocks
) (
	// clock and reset
	input  wire logic            i_clk_sys,
	input  wire logic            i_reset_n,
	// special function register write port
	input  wire wdog_pkg::sfr_wr_s i_sfr,
	// clock speed control
	input  wire logic            i_double_speed_bit,
	// status and reset pin
	output logic                 o_enabled,
	output logic [2:0]           o_prescale_sel,
	output logic                 o_rst_pin
);
	import wdog_pkg::*;

	// ************************************************************
	// derived sizes and elaboration checks
	// ************************************************************
	localparam int PULSE_W = $clog2(PULSE_LEN);

	// the three-bit select reaches seven stages, so fewer would leave codes dangling
	if (PRE_W < (2 ** PRESCALE_SEL_W) - 1 || PRE_W > 16) begin : g_bad_pre_w
		$error("prescale depth out of range");
	end
	// a very narrow counter would time out before software could ever service it
	if (CNT_W < 2 || CNT_W > 31) begin : g_bad_cnt_w
		$error("counter width out of range");
	end
	// the pulse must be long enough to count down and short enough for its counter
	if (PULSE_LEN < 2 || PULSE_LEN > 256) begin : g_bad_pulse_len
		$error("reset pulse length out of range");
	end

	// ************************************************************
	// state
	// ************************************************************
	key_state_e                 key_r,     key_nxt;
	logic                       en_r,      en_nxt;
	logic [CNT_W-1:0]           cnt_r,     cnt_nxt;
	logic [PRE_W-1:0]           pre_r,     pre_nxt;
	logic [2:0]                 sel_r,     sel_nxt;
	logic [PULSE_W-1:0]         pulse_r,   pulse_nxt;
	logic                       rst_r,     rst_nxt;
	logic                       tick;
	logic                       key_wr;
	logic                       sel_wr;
	logic                       key_done;
	logic                       pre_done;
	logic                       ovf;

	// machine cycle strobe follows the speed setting
	wdog_tick_gen u_tick (
		.i_clk_sys      (i_clk_sys),
		.i_reset_n      (i_reset_n),
		.i_double_speed (i_double_speed_bit), // R11
		.o_tick         (tick)
	);

	// ************************************************************
	// decode and prescale helpers
	// ************************************************************
	// one write strobe serves both registers, so the match lives in one place
	function automatic logic sfr_hit(input sfr_wr_s w, input logic [7:0] a);
		return w.wr && (w.addr == a);
	endfunction : sfr_hit

	// prescale mask: depth sel gives 2^sel machine cycles per count
	function automatic logic pre_wrap(input logic [PRE_W-1:0] p, input logic [2:0] s);
		logic [PRE_W-1:0] m;
		m = PRE_W'((32'h1 << s) - 32'h1);
		return ((p & m) == m);
	endfunction : pre_wrap

	// ************************************************************
	// register writes
	// ************************************************************
	// the service register has no read path at all; counter stays internal
	assign key_wr = sfr_hit(i_sfr, SERVICE_KEY_ADDR); // R8
	assign sel_wr = sfr_hit(i_sfr, PRESCALE_SEL_ADDR);

	// prescale select is a three-bit field in the next location, shown to the core
	always_comb begin
		sel_nxt = sel_r;
		if (sel_wr) begin
			sel_nxt = i_sfr.data[PRESCALE_SEL_LSB +: PRESCALE_SEL_W]; // R13
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_r <= PRESCALE_SEL_RESET;
		end else begin
			sel_r <= sel_nxt;
		end
	end

	// ************************************************************
	// key sequence tracker
	// ************************************************************
	// second value must directly follow the first; a repeated first value
	// keeps the half state so a stuttering service routine still lands
	always_comb begin
		key_nxt = key_r;
		case (key_r)
			KEY_IDLE: begin
				if (key_wr && i_sfr.data == KEY_FIRST) begin
					key_nxt = KEY_HALF;
				end
			end
			KEY_HALF: begin
				if (key_wr) begin
					if (i_sfr.data == KEY_SECOND) begin
						key_nxt = KEY_DONE;     // R2
					end else if (i_sfr.data != KEY_FIRST) begin
						key_nxt = KEY_IDLE;     // R12
					end
				end
			end
			KEY_DONE: begin
				key_nxt = KEY_IDLE;
				if (key_wr && i_sfr.data == KEY_FIRST) begin
					key_nxt = KEY_HALF;
				end
			end
			default: begin
				key_nxt = KEY_IDLE;
			end
		endcase
		// an overflow drops any sequence in progress
		if (ovf) begin
			key_nxt = KEY_IDLE;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			key_r <= KEY_IDLE;
		end else begin
			key_r <= key_nxt;
		end
	end

	// ************************************************************
	// enable, prescaler and counter
	// ************************************************************
	assign key_done = (key_r == KEY_DONE);

	// a finished key sequence both arms and services; only overflow or reset
	// ever clears the enable, so no register write can switch it off
	always_comb begin
		en_nxt   = en_r;
		cnt_nxt  = cnt_r;
		pre_nxt  = pre_r;
		pre_done = 1'b0;
		ovf      = 1'b0;
		if (key_done) begin
			en_nxt  = 1'b1;                        // R2 R4
			cnt_nxt = '0;                          // R6
			pre_nxt = '0;
		end else if (en_r && tick) begin
			pre_done = pre_wrap(pre_r, sel_r);     // R10
			pre_nxt  = pre_done ? '0 : pre_r + PRE_W'(1'h1);
			if (pre_done) begin
				if (cnt_r == {CNT_W{1'b1}}) begin
					ovf = 1'b1;                    // R5
				end else begin
					cnt_nxt = cnt_r + CNT_W'(1'h1); // R3
				end
			end
		end
		// overflow resets the device: the watchdog drops back to disabled
		if (ovf) begin
			en_nxt  = 1'b0;                        // R4
			cnt_nxt = '0;
			pre_nxt = '0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			en_r  <= 1'b0; // R1
			cnt_r <= '0;
			pre_r <= '0;
		end else begin
			en_r  <= en_nxt;
			cnt_r <= cnt_nxt;
			pre_r <= pre_nxt;
		end
	end

	// ************************************************************
	// reset pulse on the pin
	// ************************************************************
	// the pulse counts down from its length minus one to zero; a fresh overflow reloads it
	always_comb begin
		rst_nxt   = rst_r;
		pulse_nxt = pulse_r;
		if (ovf) begin
			rst_nxt   = 1'b1;                         // R9
			pulse_nxt = PULSE_W'(PULSE_LEN - 1);
		end else if (rst_r) begin
			if (pulse_r == '0) begin
				rst_nxt = 1'b0;
			end else begin
				pulse_nxt = pulse_r - PULSE_W'(1'h1); // R9
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pulse_r <= '0;
			rst_r   <= 1'b0;
		end else begin
			pulse_r <= pulse_nxt;
			rst_r   <= rst_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// every output is a plain register, so the pin never glitches
	assign o_enabled      = en_r;
	assign o_prescale_sel = sel_r;
	assign o_rst_pin      = rst_r;

endmodule : hardware_watchdog_timer

//--- wdog_monitor.sv
`timescale 1ns/1ps
// ****
// port checker
// ****
module wdog_monitor (
	input wire logic              i_clk_sys,
	input wire logic              i_reset_n,
	input wire wdog_pkg::sfr_wr_s i_sfr,
	input wire logic              i_double_speed_bit,
	input wire logic              o_enabled,
	input wire logic [2:0]        o_prescale_sel,
	input wire logic              o_rst_pin
);
	import wdog_pkg::*;
	logic [7:0] hi_r;
	logic [7:0] hi_nxt;
	wire k1 = i_sfr.wr && i_sfr.addr == SERVICE_KEY_ADDR && i_sfr.data == KEY_FIRST;
	wire k2 = i_sfr.wr && i_sfr.addr == SERVICE_KEY_ADDR && i_sfr.data == KEY_SECOND;
	wire sw = i_sfr.wr && i_sfr.addr == PRESCALE_SEL_ADDR;
	// length of the running pulse; a counter because 96 is too long to unroll
	always_comb hi_nxt = o_rst_pin ? hi_r + 8'h01 : 8'h00;
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) hi_r <= 8'h00;
		else hi_r <= hi_nxt;
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	AST_ARM:
		assert property (k1 ##1 k2 |-> ##2 o_enabled) else $error("arm missed");
	AST_ARM_CAUSE:
		assert property ($rose(o_enabled) |-> $past(k1, 3) && $past(k2, 2)) else $error("bad arm");
	AST_STAYS:
		assert property ($fell(o_enabled) |-> o_rst_pin) else $error("disarmed");
	AST_OVF:
		assert property ($rose(o_rst_pin) |-> $past(o_enabled) && !o_enabled) else $error("ovf");
	AST_PULSE_LEN:
		assert property ($fell(o_rst_pin) |-> hi_r == 8'h60) else $error("pulse length");
	AST_PULSE_MAX:
		assert property (hi_r <= 8'h60) else $error("pulse too long");
	AST_SEL_WR:
		assert property (sw |=> o_prescale_sel == $past(i_sfr.data[2:0])) else $error("sel");
	AST_SEL_HOLD:
		assert property (!sw |=> $stable(o_prescale_sel)) else $error("sel moved");
	AST_IDLE_QUIET:
		assert property (!o_enabled && !o_rst_pin |=> !o_rst_pin) else $error("idle ovf");
endmodule : wdog_monitor
bind hardware_watchdog_timer wdog_monitor i_wdog_monitor (.i_clk_sys(i_clk_sys),
	.i_reset_n(i_reset_n), .i_sfr(i_sfr), .i_double_speed_bit(i_double_speed_bit),
	.o_enabled(o_enabled), .o_prescale_sel(o_prescale_sel), .o_rst_pin(o_rst_pin));

//--- hardware_watchdog_timer_tb.sv
`timescale 1ns/1ps
module hardware_watchdog_timer_tb;
	import wdog_pkg::*;
	logic       i_clk_sys, i_reset_n, i_double_speed_bit, o_enabled, o_rst_pin;
	logic [2:0] o_prescale_sel;
	sfr_wr_s    i_sfr;
	int         err_count, checks, n;
	hardware_watchdog_timer i_hardware_watchdog_timer (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_sfr(i_sfr), .i_double_speed_bit(i_double_speed_bit),
		.o_enabled(o_enabled), .o_prescale_sel(o_prescale_sel), .o_rst_pin(o_rst_pin));
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done
	// inputs change 1 ns after the edge so the design samples settled values
	task automatic step(input int k);
		repeat (k) @(posedge i_clk_sys);
		#1;
	endtask : step
	// holds the strobe; back-to-back writes need no idle cycle between them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr = '{1'b1, a, d};
		step(1);
	endtask : wr
	task automatic rel;
		i_sfr.wr = 1'b0;
		step(1);
	endtask : rel
	// ****
	// scenarios
	// ****
	task automatic t_bad_keys;
		chk("en reset", {o_enabled, o_rst_pin, o_prescale_sel}, 0);
		wr(8'hA6, 8'hE1); wr(8'hA6, 8'h1E); wr(8'hA6, 8'h55); wr(8'hA6, 8'hE1); rel; step(3);
		chk("en broken", o_enabled, 0);
	endtask : t_bad_keys
	task automatic t_select;
		wr(8'hA7, 8'hFF); rel;
		chk("sel", o_prescale_sel, 3'h7);
		wr(8'hA7, 8'h00); rel;
		chk("sel", o_prescale_sel, 3'h0);
	endtask : t_select
	task automatic t_arm;
		wr(8'hA6, 8'h1E); wr(8'hA6, 8'h1E); wr(8'hA6, 8'hE1);
		chk("en early", o_enabled, 0);
		rel;
		chk("en", o_enabled, 1);
		wr(8'hA6, 8'h00); wr(8'hA7, 8'h00); rel; step(2);
		chk("en kept", o_enabled, 1);
	endtask : t_arm
	// a late service moves the overflow; six clocks per machine cycle
	task automatic t_overflow;
		i_double_speed_bit = 1'b1;
		step(600);
		wr(8'hA6, 8'h1E); wr(8'hA6, 8'hE1); rel;
		for (n = 0; !o_rst_pin && n < 99000; n++) step(1);
		chk("ovf time", n >= 98295 && n <= 98315, 1);
		chk("en ovf", o_enabled, 0);
		for (n = 0; o_rst_pin && n < 200; n++) step(1);
		chk("pulse", n, 96);
	endtask : t_overflow
	task automatic t_reset_mid;
		wr(8'hA7, 8'h05); wr(8'hA6, 8'h1E); wr(8'hA6, 8'hE1); rel; step(2);
		chk("en mid", o_enabled, 1);
		i_reset_n = 1'b0;
		#1;
		chk("en rst", {o_enabled, o_rst_pin, o_prescale_sel}, 0);
		step(2);
		i_reset_n = 1'b1;
		wr(8'hA6, 8'h1E); wr(8'hA6, 8'hE1); rel;
		chk("en rearm", o_enabled, 1);
	endtask : t_reset_mid
	initial begin
		i_sfr = '0;
		i_double_speed_bit = 1'b0;
		i_reset_n = 1'b0;
		step(5);
		i_reset_n = 1'b1;
		t_bad_keys; t_select; t_arm; t_overflow; t_reset_mid;
		test_done;
	end
	// tests take about 99k cycles; cut off at 110k
	initial begin
		#550000;
		err_count++;
		test_done;
	end
endmodule : hardware_watchdog_timer_tb
